// ---- include/sfs_defs.svh ----
`ifndef SFS_DEFS_SVH
`define SFS_DEFS_SVH

// stored result and register widths
`define SFS_DATA_W 24
`define SFS_REG_W 24
`define SFS_LIM_W 12
`define SFS_CMP_MSB 23
`define SFS_CMP_LSB 12
`define SFS_STAT_W 8

// queue geometry
`define SFS_DEPTH 16
`define SFS_PTR_W 4
`define SFS_CNT_W 5
`define SFS_CNT_FULL 5'h10
`define SFS_CNT_ONE 5'h01
`define SFS_CNT_ZERO 5'h00
`define SFS_PTR_ONE 4'h1
`define SFS_PTR_ZERO 4'h0
`define SFS_CHAN_W 4
`define SFS_CHANNELS 16

// register map
`define SFS_ADDR_W 6
`define SFS_ADDR_LIMIT 6'h3c
`define SFS_ADDR_READOUT 6'h3d
`define SFS_ADDR_STATUS 6'h3b

// reset values
`define SFS_LIMIT_RST 24'hfff000
`define SFS_READOUT_RST 24'h000000

// status bit positions
`define SFS_STAT_EMPTY 0
`define SFS_STAT_WM 1
`define SFS_STAT_LO 3
`define SFS_STAT_HI 4

`endif

// ---- include/sfs_pkg.sv ----
`include "sfs_defs.svh"

package sfs_pkg;

  typedef struct packed {
    logic [`SFS_CHAN_W-1:0] channel;
    logic [`SFS_DATA_W-1:0] data;
  } sfs_sample_t;

  typedef struct packed {
    logic [`SFS_LIM_W-1:0] upper_limit_value;
    logic [`SFS_LIM_W-1:0] lower_limit_value;
  } sfs_limit_t;

  typedef struct packed {
    logic upper_limit_hit_flag;
    logic lower_limit_hit_flag;
    logic watermark;
    logic empty;
  } sfs_flags_t;

  typedef enum logic [1:0] {
    sfs_rd_idle = 2'b01,
    sfs_rd_fetch = 2'b10
  } sfs_rd_state_t;

endpackage

// ---- design/sfs_queue_mem.sv ----
`timescale 1ns/100ps
`include "sfs_defs.svh"

module sfs_queue_mem
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [`SFS_PTR_W-1:0] wr_addr,
  input wire logic [`SFS_DATA_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [`SFS_PTR_W-1:0] rd_addr,
  output logic [`SFS_DATA_W-1:0] rd_data_ff
);

  logic [`SFS_DATA_W-1:0] mem [0:`SFS_DEPTH-1];

  // storage carries no reset, only the read register does
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_ff <= `SFS_READOUT_RST;
    end
    else if (rd_en)
    begin
      rd_data_ff <= mem[rd_addr];
    end
  end

endmodule // sfs_queue_mem

// ---- design/sfs_top.sv ----
`timescale 1ns/100ps
`include "sfs_defs.svh"

// Overview of operation
// - watermark flag is 1 while the queue is enabled and stored count is at or above watermark level
// - watermark flag drops to 0 once stored count falls below watermark level
// - each interrupt output follows its flag in the very same cycle
// - enabled queue with nothing written shows empty flag 1
// - empty flag sets with the read that takes the last entry
// - a clear command discards all entries and sets empty flag
// - disabled queue always shows empty flag 1
// - empty flag is 0 whenever the queue is enabled and at least one entry is stored
// - reset shows empty 1, watermark 0; status flags are read-only
// - enabled channel result at or above upper limit sets upper hit flag
// - enabled channel result at or below lower limit sets lower hit flag
// - limit register resets to upper all ones, lower zero
// - limit register is 24-bit read/write at address 0x3c
// - stored results are not re-checked when limits change
// - reads at address 0x3d return 24-bit queue data, zero after reset
// - limit hit flags and interrupts clear when queue becomes empty
module sfs_top
  import sfs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic queue_enable,
  input wire logic queue_clear,
  input wire logic [`SFS_CNT_W-1:0] watermark_level,
  input wire logic smp_valid,
  input wire sfs_sample_t smp_in,
  input wire logic [`SFS_CHANNELS-1:0] channel_limit_check_enable,
  input wire logic [`SFS_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`SFS_REG_W-1:0] reg_wdata,
  output logic [`SFS_REG_W-1:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  output sfs_flags_t status_flags_ff,
  output sfs_flags_t irq_flags_ff,
  output logic [`SFS_CNT_W-1:0] sample_count_ff
);

  logic [1:0] rst_sync_ff;
  logic rst_n;
  sfs_limit_t limit_ff;
  logic [`SFS_PTR_W-1:0] wr_ptr_ff;
  logic [`SFS_PTR_W-1:0] rd_ptr_ff;
  logic [`SFS_CNT_W-1:0] nxt_count;
  sfs_flags_t nxt_flags;
  sfs_rd_state_t rd_state_ff;
  logic [`SFS_ADDR_W-1:0] rd_addr_ff;
  logic popped_ff;
  logic [`SFS_DATA_W-1:0] mem_rd_data;
  logic rd_take;
  logic pop;
  logic push;
  logic hit_upper;
  logic hit_lower;
  logic nxt_empty;

  // async assert, sync release; stage 0 feeds stage 1 only
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_sync_ff <= 2'b00;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  function automatic logic sfs_addr_hit(
    input logic [`SFS_ADDR_W-1:0] addr,
    input logic [`SFS_ADDR_W-1:0] target
  );
    sfs_addr_hit = (addr == target);
  endfunction

  function automatic logic [`SFS_REG_W-1:0] sfs_status_word(input sfs_flags_t f);
    logic [`SFS_REG_W-1:0] w;
    w = '0;
    w[`SFS_STAT_EMPTY] = f.empty;
    w[`SFS_STAT_WM] = f.watermark;
    w[`SFS_STAT_LO] = f.lower_limit_hit_flag;
    w[`SFS_STAT_HI] = f.upper_limit_hit_flag;
    sfs_status_word = w;
  endfunction

  // one read in flight; a second strobe during fetch is dropped
  assign rd_take = reg_rd && (rd_state_ff == sfs_rd_idle);
  assign pop = rd_take && sfs_addr_hit(reg_addr, `SFS_ADDR_READOUT) && queue_enable
               && (sample_count_ff != `SFS_CNT_ZERO) && !queue_clear;
  // full queue drops the new sample unless a pop frees a slot
  assign push = smp_valid && queue_enable && !queue_clear
                && ((sample_count_ff != `SFS_CNT_FULL) || pop);

  // only the top bits of a result meet the 12-bit limits
  // checked once on entry, so later limit writes leave stored hits alone
  assign hit_upper = push && channel_limit_check_enable[smp_in.channel]
                     && (smp_in.data[`SFS_CMP_MSB:`SFS_CMP_LSB] >= limit_ff.upper_limit_value);
  assign hit_lower = push && channel_limit_check_enable[smp_in.channel]
                     && (smp_in.data[`SFS_CMP_MSB:`SFS_CMP_LSB] <= limit_ff.lower_limit_value);

  always_comb
  begin
    nxt_count = sample_count_ff;
    if (queue_clear)
    begin
      nxt_count = `SFS_CNT_ZERO;
    end
    else if (push && !pop)
    begin
      nxt_count = sample_count_ff + `SFS_CNT_ONE;
    end
    else if (pop && !push)
    begin
      nxt_count = sample_count_ff - `SFS_CNT_ONE;
    end
  end

  // flags come from next-state values so they move with the count edge
  always_comb
  begin
    nxt_empty = !queue_enable || (nxt_count == `SFS_CNT_ZERO);
    nxt_flags.empty = nxt_empty;
    nxt_flags.watermark = queue_enable && (nxt_count >= watermark_level);
    nxt_flags.upper_limit_hit_flag = !nxt_empty && (status_flags_ff.upper_limit_hit_flag || hit_upper);
    nxt_flags.lower_limit_hit_flag = !nxt_empty && (status_flags_ff.lower_limit_hit_flag || hit_lower);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sample_count_ff <= `SFS_CNT_ZERO;
    end
    else
    begin
      sample_count_ff <= nxt_count;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= `SFS_PTR_ZERO;
      rd_ptr_ff <= `SFS_PTR_ZERO;
    end
    else if (queue_clear)
    begin
      wr_ptr_ff <= `SFS_PTR_ZERO;
      rd_ptr_ff <= `SFS_PTR_ZERO;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + `SFS_PTR_ONE;
      end
      if (pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + `SFS_PTR_ONE;
      end
    end
  end

  // status and interrupts share one next value, never a cycle apart
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_flags_ff <= '{upper_limit_hit_flag: 1'b0, lower_limit_hit_flag: 1'b0,
                           watermark: 1'b0, empty: 1'b1};
      irq_flags_ff <= '{upper_limit_hit_flag: 1'b0, lower_limit_hit_flag: 1'b0,
                        watermark: 1'b0, empty: 1'b1};
    end
    else
    begin
      status_flags_ff <= nxt_flags;
      irq_flags_ff <= nxt_flags;
    end
  end

  // status and readout addresses ignore writes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      limit_ff <= `SFS_LIMIT_RST;
    end
    else if (reg_wr && sfs_addr_hit(reg_addr, `SFS_ADDR_LIMIT))
    begin
      limit_ff <= reg_wdata;
    end
  end

  sfs_queue_mem u_mem
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr_en(push),
    .wr_addr(wr_ptr_ff),
    .wr_data(smp_in.data),
    .rd_en(pop),
    .rd_addr(rd_ptr_ff),
    .rd_data_ff(mem_rd_data)
  );

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_state_ff <= sfs_rd_idle;
      rd_addr_ff <= '0;
      popped_ff <= 1'b0;
    end
    else
    begin
      unique case (rd_state_ff)
        sfs_rd_idle:
        begin
          if (rd_take)
          begin
            rd_state_ff <= sfs_rd_fetch;
            rd_addr_ff <= reg_addr;
            popped_ff <= pop;
          end
        end
        sfs_rd_fetch:
        begin
          rd_state_ff <= sfs_rd_idle;
          popped_ff <= 1'b0;
        end
        default:
        begin
          rd_state_ff <= sfs_rd_idle;
        end
      endcase
    end
  end

  // unmapped addresses and a readout of an empty queue answer zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_ff <= `SFS_READOUT_RST;
      reg_rvalid_ff <= 1'b0;
    end
    else
    begin
      reg_rvalid_ff <= (rd_state_ff == sfs_rd_fetch);
      if (rd_state_ff == sfs_rd_fetch)
      begin
        if (sfs_addr_hit(rd_addr_ff, `SFS_ADDR_READOUT))
        begin
          reg_rdata_ff <= popped_ff ? mem_rd_data : `SFS_READOUT_RST;
        end
        else if (sfs_addr_hit(rd_addr_ff, `SFS_ADDR_LIMIT))
        begin
          reg_rdata_ff <= limit_ff;
        end
        else if (sfs_addr_hit(rd_addr_ff, `SFS_ADDR_STATUS))
        begin
          reg_rdata_ff <= sfs_status_word(status_flags_ff);
        end
        else
        begin
          reg_rdata_ff <= '0;
        end
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_wm_set;
    $past(queue_enable) && (sample_count_ff >= $past(watermark_level)) |-> status_flags_ff.watermark;
  endproperty
  a_wm_set: assert property (p_wm_set) else $error("watermark flag not set");

  property p_wm_clr;
    sample_count_ff < $past(watermark_level) |-> !status_flags_ff.watermark;
  endproperty
  a_wm_clr: assert property (p_wm_clr) else $error("watermark flag not cleared");

  property p_irq_track;
    irq_flags_ff == status_flags_ff;
  endproperty
  a_irq_track: assert property (p_irq_track) else $error("interrupt differs from flag");

  property p_empty_unwritten;
    queue_enable && (sample_count_ff == `SFS_CNT_ZERO) && !push |=> status_flags_ff.empty;
  endproperty
  a_empty_unwritten: assert property (p_empty_unwritten) else $error("empty flag low with no data");

  property p_last_read;
    pop && !push && (sample_count_ff == `SFS_CNT_ONE) |=> status_flags_ff.empty && irq_flags_ff.empty;
  endproperty
  a_last_read: assert property (p_last_read) else $error("empty not set by last read");

  property p_clear;
    queue_clear |=> status_flags_ff.empty && (sample_count_ff == `SFS_CNT_ZERO);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not empty queue");

  property p_disabled;
    !queue_enable |=> status_flags_ff.empty && !status_flags_ff.watermark;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled queue not empty");

  property p_nonempty;
    queue_enable && push |=> !status_flags_ff.empty && (sample_count_ff != `SFS_CNT_ZERO);
  endproperty
  a_nonempty: assert property (p_nonempty) else $error("empty flag set with data");

  property p_upper_hit;
    hit_upper |=> status_flags_ff.upper_limit_hit_flag;
  endproperty
  a_upper_hit: assert property (p_upper_hit) else $error("upper hit not flagged");

  property p_lower_hit;
    hit_lower |=> status_flags_ff.lower_limit_hit_flag;
  endproperty
  a_lower_hit: assert property (p_lower_hit) else $error("lower hit not flagged");

  property p_limit_clr;
    status_flags_ff.empty |-> !status_flags_ff.upper_limit_hit_flag && !irq_flags_ff.lower_limit_hit_flag;
  endproperty
  a_limit_clr: assert property (p_limit_clr) else $error("limit flag held while empty");

  property p_read_answer;
    rd_take |=> !reg_rvalid_ff ##1 reg_rvalid_ff ##1 !reg_rvalid_ff;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer timing wrong");

  property p_empty_readout;
    rd_take && sfs_addr_hit(reg_addr, `SFS_ADDR_READOUT) && !pop |-> ##2 (reg_rdata_ff == `SFS_READOUT_RST);
  endproperty
  a_empty_readout: assert property (p_empty_readout) else $error("empty readout not zero");

  property p_pop_count;
    pop && !push |=> sample_count_ff == $past(sample_count_ff) - `SFS_CNT_ONE;
  endproperty
  a_pop_count: assert property (p_pop_count) else $error("pop did not decrement count");

  property p_limit_readback;
    reg_wr && sfs_addr_hit(reg_addr, `SFS_ADDR_LIMIT) |=> limit_ff == $past(reg_wdata);
  endproperty
  a_limit_readback: assert property (p_limit_readback) else $error("limit write lost");

  property p_cov_last_read;
    pop && (sample_count_ff == `SFS_CNT_ONE) ##1 status_flags_ff.empty;
  endproperty
  c_last_read: cover property (p_cov_last_read);

  property p_cov_wm;
    !status_flags_ff.watermark ##1 status_flags_ff.watermark;
  endproperty
  c_wm: cover property (p_cov_wm);

  property p_cov_upper;
    hit_upper ##1 status_flags_ff.upper_limit_hit_flag;
  endproperty
  c_upper: cover property (p_cov_upper);

  property p_cov_readout;
    pop ##2 reg_rvalid_ff;
  endproperty
  c_readout: cover property (p_cov_readout);

endmodule // sfs_top

// ---- tb/sfs_host_model.sv ----
`timescale 1ns/100ps
`include "sfs_defs.svh"

module sfs_host_model
(
  input wire logic mclk,
  output logic [`SFS_ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [`SFS_REG_W-1:0] reg_wdata,
  input wire logic [`SFS_REG_W-1:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff
);
  initial
  begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 24'h000000;
  end

  task automatic wr(input logic [`SFS_ADDR_W-1:0] a, input logic [`SFS_REG_W-1:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // released lines show no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // strobe only; the caller watches the answer itself
  task automatic rd_start(input logic [`SFS_ADDR_W-1:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask

  // answers arrive two edges after the take; waiting on rvalid keeps reads spaced
  task automatic rd(input logic [`SFS_ADDR_W-1:0] a, output logic [`SFS_REG_W-1:0] d, output logic ok);
    int i;
    ok = 1'b0;
    d = 24'h000000;
    rd_start(a);
    for (i = 0; i < 6 && !ok; i++)
    begin
      @(negedge mclk);
      if (reg_rvalid_ff === 1'b1)
      begin
        ok = 1'b1;
        d = reg_rdata_ff;
      end
    end
  endtask
endmodule // sfs_host_model

// ---- tb/test_sample_fifo_status_threshold.sv ----
`timescale 1ns/100ps
`include "sfs_defs.svh"

module test_sample_fifo_status_threshold;
  import sfs_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic queue_enable = 1'b0;
  logic queue_clear = 1'b0;
  logic [`SFS_CNT_W-1:0] watermark_level = 5'h03;
  logic smp_valid = 1'b0;
  sfs_sample_t smp_in = '0;
  logic [`SFS_CHANNELS-1:0] chen = 16'h0002;
  logic [`SFS_ADDR_W-1:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [`SFS_REG_W-1:0] reg_wdata;
  logic [`SFS_REG_W-1:0] reg_rdata_ff;
  logic reg_rvalid_ff;
  sfs_flags_t status_flags_ff;
  sfs_flags_t irq_flags_ff;
  logic [`SFS_CNT_W-1:0] sample_count_ff;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  always #20 mclk = ~mclk;

  sfs_top dut_u (.mclk(mclk), .rst_b(rst_b), .queue_enable(queue_enable), .queue_clear(queue_clear),
    .watermark_level(watermark_level), .smp_valid(smp_valid), .smp_in(smp_in),
    .channel_limit_check_enable(chen), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .status_flags_ff(status_flags_ff), .irq_flags_ff(irq_flags_ff), .sample_count_ff(sample_count_ff));

  sfs_host_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff));

  task automatic test_done();
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_word(input logic [`SFS_REG_W-1:0] got, input logic [`SFS_REG_W-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  // flags as {upper, lower, watermark, empty}; the interrupt copy must agree
  task automatic chk_flags(input logic [3:0] exp, input logic [`SFS_CNT_W-1:0] cnt);
    compares++;
    if (status_flags_ff !== exp || irq_flags_ff !== exp || sample_count_ff !== cnt)
    begin
      n_fail++;
      $display("mismatch at %0t: flags %b irq %b count %0d expected %b %0d", $time,
        status_flags_ff, irq_flags_ff, sample_count_ff, exp, cnt);
    end
  endtask

  task automatic rdchk(input logic [`SFS_ADDR_W-1:0] a, input logic [`SFS_REG_W-1:0] exp);
    logic [`SFS_REG_W-1:0] d;
    logic ok;
    host_u.rd(a, d, ok);
    if (!ok)
      d = 24'hxxxxxx;
    chk_word(d, exp);
  endtask

  task automatic push(input logic [3:0] ch, input logic [`SFS_DATA_W-1:0] d);
    @(negedge mclk);
    smp_in = {ch, d};
    smp_valid = 1'b1;
    @(negedge mclk);
    smp_valid = 1'b0;
    smp_in = ~{ch, d};
  endtask

  task automatic pulse_clear();
    @(negedge mclk);
    queue_clear = 1'b1;
    @(negedge mclk);
    queue_clear = 1'b0;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles >= 3000)
    begin
      n_fail++;
      test_done();
    end
  end

  initial
  begin
    repeat (3) @(negedge mclk);
    rst_b = 1'b1;
    repeat (3) @(negedge mclk);
    chk_flags(4'b0001, 5'h00);
    rdchk(`SFS_ADDR_LIMIT, `SFS_LIMIT_RST);
    rdchk(`SFS_ADDR_READOUT, 24'h000000);
    push(4'h1, 24'h4a5123);
    chk_flags(4'b0001, 5'h00);
    host_u.wr(`SFS_ADDR_LIMIT, 24'h800100);
    rdchk(`SFS_ADDR_LIMIT, 24'h800100);
    queue_enable = 1'b1;
    @(negedge mclk);
    chk_flags(4'b0001, 5'h00);
    push(4'h1, 24'h4a5123);
    chk_flags(4'b0000, 5'h01);
    push(4'h2, 24'h050000);
    chk_flags(4'b0000, 5'h02);
    push(4'h1, 24'h800000);
    chk_flags(4'b1010, 5'h03);
    push(4'h1, 24'h100fff);
    chk_flags(4'b1110, 5'h04);
    host_u.wr(`SFS_ADDR_STATUS, 24'hffffff);
    rdchk(`SFS_ADDR_STATUS, 24'h00001a);
    rdchk(6'h00, 24'h000000);
    rdchk(`SFS_ADDR_READOUT, 24'h4a5123);
    chk_flags(4'b1110, 5'h03);
    rdchk(`SFS_ADDR_READOUT, 24'h050000);
    chk_flags(4'b1100, 5'h02);
    rdchk(`SFS_ADDR_READOUT, 24'h800000);
    chk_flags(4'b1100, 5'h01);
    // last entry: empty and limit clears must show right after the take edge
    host_u.rd_start(`SFS_ADDR_READOUT);
    chk_flags(4'b0001, 5'h00);
    @(negedge mclk);
    chk_word((reg_rvalid_ff === 1'b1) ? reg_rdata_ff : 24'hxxxxxx, 24'h100fff);
    rdchk(`SFS_ADDR_READOUT, 24'h000000);
    chk_flags(4'b0001, 5'h00);
    push(4'h1, 24'h900000);
    host_u.wr(`SFS_ADDR_LIMIT, `SFS_LIMIT_RST);
    chk_flags(4'b1000, 5'h01);
    push(4'h1, 24'h123456);
    queue_enable = 1'b0;
    @(negedge mclk);
    chk_flags(4'b0001, 5'h02);
    queue_enable = 1'b1;
    pulse_clear();
    chk_flags(4'b0001, 5'h00);
    // one more than the depth: the last sample is dropped
    repeat (17) push(4'h1, 24'h123456);
    chk_flags(4'b0010, 5'h10);
    test_done();
  end
endmodule // test_sample_fifo_status_threshold
